// >>> verilog/flame_sup_pkg.sv
// package for the flame supervision logic: settings, phase ranges, test timing
// assumes a 125 MHz system clock and digitised flame indications from outside
//
// Behaviour
// - two flame channels, A optical, B ionisation
// - six selections: pilot/operating/stray, gas and oil
// - phases 40..50 use pilot selection of fuel
// - phases 52..62 use operating selection of fuel
// - all other phases use stray-light selection
// - single-detector: error if both channels connected
// - either-channel: flame if A or B
// - A-exclusive: flame if A and not B
// - A-only: flame follows A, B ignored
// - B-exclusive: flame if B and not A
// - B-only: flame follows B, A ignored
// - both: A and B; not for stray light
// - forbidden channel flame in operation: shutdown
// - self-test raises optical detector supply
// - self-test expects channel A flame-off
// - after good test resume until next period

package flame_sup_pkg;

  // ==========================================================
  // combination settings
  localparam logic [2:0] SEL_SINGLE  = 3'h0;
  localparam logic [2:0] SEL_EITHER  = 3'h1;
  localparam logic [2:0] SEL_A_NOT_B = 3'h2;
  localparam logic [2:0] SEL_A_ONLY  = 3'h3;
  localparam logic [2:0] SEL_B_NOT_A = 3'h4;
  localparam logic [2:0] SEL_B_ONLY  = 3'h5;
  localparam logic [2:0] SEL_BOTH    = 3'h6;

  // ==========================================================
  // sequencer phase ranges
  localparam logic [7:0] PILOT_FIRST = 8'h28;
  localparam logic [7:0] PILOT_LAST  = 8'h32;
  localparam logic [7:0] OPER_FIRST  = 8'h34;
  localparam logic [7:0] OPER_LAST   = 8'h3E;

  // ==========================================================
  // self-test timing
  localparam int unsigned CLK_HZ        = 125_000_000;
  localparam int unsigned TEST_PERIOD_MS = 3600000;
  localparam int unsigned TEST_TIME_MS   = 500;
  localparam longint unsigned TEST_PERIOD_CYC =
    longint'(TEST_PERIOD_MS) * longint'(CLK_HZ / 1000);
  localparam longint unsigned TEST_TIME_CYC =
    longint'(TEST_TIME_MS) * longint'(CLK_HZ / 1000);
  // supply edge plus two sync stages before channel A shows flame again
  localparam logic [1:0] RECOVER_CYC = 2'h3;

  typedef enum logic [1:0]
  {
    ST_RUN  = 2'b01,
    ST_TEST = 2'b10
  } test_state_t;

endpackage : flame_sup_pkg

// >>> verilog/flame_supervision_logic.sv
// flame supervision: channel combination per phase/fuel and optical self-test
// assumes flame inputs are asynchronous pins; phase/fuel/settings on clk_i
`timescale 1ns/100ps
`default_nettype none

module flame_supervision_logic #(
  parameter int unsigned PHASE_W     = 8,
  parameter longint unsigned TEST_PERIOD = flame_sup_pkg::TEST_PERIOD_CYC,
  parameter longint unsigned TEST_TIME   = flame_sup_pkg::TEST_TIME_CYC
) (
  // clock and reset
  input  wire logic               clk_i,
  input  wire logic               rst_i,
  // detector pins
  input  wire logic               flame_channel_a_i,
  input  wire logic               flame_channel_b_i,
  input  wire logic               a_connected_i,
  input  wire logic               b_connected_i,
  // sequencer
  input  wire logic [PHASE_W-1:0] phase_i,
  input  wire logic               fuel_oil_i,
  input  wire logic               self_test_enable_i,
  // six selections
  input  wire logic [2:0]         gas_pilot_select_i,
  input  wire logic [2:0]         oil_pilot_select_i,
  input  wire logic [2:0]         gas_operating_select_i,
  input  wire logic [2:0]         oil_operating_select_i,
  input  wire logic [2:0]         gas_stray_light_select_i,
  input  wire logic [2:0]         oil_stray_light_select_i,
  // results
  output logic                    flame_o,
  output logic                    config_error_o,
  output logic                    test_supply_raise_o,
  output logic                    self_test_active_o,
  output logic                    detector_fault_o,
  output logic                    shutdown_o
);

  // ==========================================================
  // input synchronisers
  // asynchronous pins pass two flops before any logic reads them
  localparam int unsigned PIN_N = 4;

  logic [PIN_N-1:0] pin_raw;
  logic [PIN_N-1:0] pin_meta;
  logic [PIN_N-1:0] pin_sync;

  assign pin_raw[0] = flame_channel_a_i;
  assign pin_raw[1] = flame_channel_b_i;
  assign pin_raw[2] = a_connected_i;
  assign pin_raw[3] = b_connected_i;

  for (genvar gi = 0; gi < PIN_N; gi++)
  begin : g_sync
    always_ff @(posedge clk_i)
    begin
      if (rst_i)
      begin
        pin_meta[gi] <= 1'b0;
        pin_sync[gi] <= 1'b0;
      end
      else
      begin
        pin_meta[gi] <= pin_raw[gi];
        pin_sync[gi] <= pin_meta[gi];
      end
    end
  end

  logic fa;
  logic fb;
  logic a_present;
  logic b_present;

  assign fa        = pin_sync[0];
  assign fb        = pin_sync[1];
  assign a_present = pin_sync[2];
  assign b_present = pin_sync[3];

  // ==========================================================
  // selection by phase and fuel
  logic       in_pilot;
  logic       in_oper;
  logic [2:0] pilot_sel;
  logic [2:0] oper_sel;
  logic [2:0] stray_sel;
  logic [2:0] sel;

  assign in_pilot = (phase_i >= PHASE_W'(flame_sup_pkg::PILOT_FIRST))
                 && (phase_i <= PHASE_W'(flame_sup_pkg::PILOT_LAST));
  assign in_oper  = (phase_i >= PHASE_W'(flame_sup_pkg::OPER_FIRST))
                 && (phase_i <= PHASE_W'(flame_sup_pkg::OPER_LAST));

  // fuel first, so each phase range sees one three-bit code
  always_comb
  begin
    if (fuel_oil_i)
    begin
      pilot_sel = oil_pilot_select_i;
      oper_sel  = oil_operating_select_i;
      stray_sel = oil_stray_light_select_i;
    end
    else
    begin
      pilot_sel = gas_pilot_select_i;
      oper_sel  = gas_operating_select_i;
      stray_sel = gas_stray_light_select_i;
    end
  end

  always_comb
  begin
    if (in_pilot)
    begin
      sel = pilot_sel;
    end
    else if (in_oper)
    begin
      sel = oper_sel;
    end
    else
    begin
      sel = stray_sel;
    end
  end

  // ==========================================================
  // combination
  logic next_flame;
  logic forbidden;
  logic single_err;

  always_comb
  begin
    next_flame = 1'b0;
    case (sel)
      flame_sup_pkg::SEL_SINGLE:
      begin
        next_flame = fa | fb;
      end
      flame_sup_pkg::SEL_EITHER:
      begin
        next_flame = fa | fb;
      end
      flame_sup_pkg::SEL_A_NOT_B:
      begin
        next_flame = fa & ~fb;
      end
      flame_sup_pkg::SEL_A_ONLY:
      begin
        next_flame = fa;
      end
      flame_sup_pkg::SEL_B_NOT_A:
      begin
        next_flame = fb & ~fa;
      end
      flame_sup_pkg::SEL_B_ONLY:
      begin
        next_flame = fb;
      end
      flame_sup_pkg::SEL_BOTH:
      begin
        // not valid for stray light: no flame then, to stay fail-safe
        next_flame = (in_pilot | in_oper) ? (fa & fb) : 1'b0;
      end
      default:
      begin
        next_flame = 1'b0;
      end
    endcase
  end

  // flame on a channel the exclusive operating setting forbids
  always_comb
  begin
    forbidden = 1'b0;
    if (in_oper)
    begin
      case (oper_sel)
        flame_sup_pkg::SEL_A_NOT_B:
        begin
          forbidden = fb;
        end
        flame_sup_pkg::SEL_B_NOT_A:
        begin
          forbidden = fa;
        end
        default:
        begin
          forbidden = 1'b0;
        end
      endcase
    end
  end

  assign single_err = (sel == flame_sup_pkg::SEL_SINGLE) && a_present && b_present;

  // ==========================================================
  // self-test sequencer
  // counters are 64 bits so an hour-long period fits at full clock rate
  flame_sup_pkg::test_state_t state;
  flame_sup_pkg::test_state_t next_state;
  logic                       in_test;
  logic [63:0]                period_cnt;
  logic [63:0]                test_cnt;
  logic                       seen_off;
  logic                       period_done;
  logic                       window_done;
  logic                       test_fail;
  logic [1:0]                 recover_cnt;
  logic                       hold_flame;

  assign in_test     = (state == flame_sup_pkg::ST_TEST);
  assign period_done = self_test_enable_i && (period_cnt >= TEST_PERIOD - 64'h1);
  assign window_done = (test_cnt >= TEST_TIME - 64'h1);
  assign test_fail   = in_test && window_done && !seen_off && fa;

  always_comb
  begin
    next_state = state;
    case (state)
      flame_sup_pkg::ST_RUN:
      begin
        if (period_done)
          next_state = flame_sup_pkg::ST_TEST;
      end
      flame_sup_pkg::ST_TEST:
      begin
        if (window_done)
          next_state = flame_sup_pkg::ST_RUN;
      end
      default:
      begin
        next_state = flame_sup_pkg::ST_RUN;
      end
    endcase
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      state <= flame_sup_pkg::ST_RUN;
    else
      state <= next_state;
  end

  // period runs only in normal evaluation; disabling restarts it
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      period_cnt <= 64'h0;
    else if (in_test || !self_test_enable_i || period_done)
      period_cnt <= 64'h0;
    else
      period_cnt <= period_cnt + 64'h1;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      test_cnt <= 64'h0;
    else if (!in_test)
      test_cnt <= 64'h0;
    else if (!window_done)
      test_cnt <= test_cnt + 64'h1;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      seen_off <= 1'b0;
    else if (!in_test)
      seen_off <= 1'b0;
    else if (!fa)
      seen_off <= 1'b1;
  end

  // channel A stays low a few cycles after the supply drops back
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      recover_cnt <= 2'h0;
    else if (in_test && window_done)
      recover_cnt <= flame_sup_pkg::RECOVER_CYC;
    else if (recover_cnt != 2'h0)
      recover_cnt <= recover_cnt - 2'h1;
  end

  assign hold_flame = in_test || (recover_cnt != 2'h0);

  // ==========================================================
  // outputs
  // the raised supply forces channel A off, so the verdict is frozen
  // over the window and until the cell has recovered
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      flame_o <= 1'b0;
    else if (!hold_flame)
      flame_o <= next_flame & ~forbidden;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      config_error_o <= 1'b0;
    else
      config_error_o <= single_err;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      test_supply_raise_o <= 1'b0;
    else
      test_supply_raise_o <= in_test;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      self_test_active_o <= 1'b0;
    else
      self_test_active_o <= in_test;
  end

  // fault and shutdown latch until reset; safety outputs must not self-clear
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      detector_fault_o <= 1'b0;
    else if (test_fail)
      detector_fault_o <= 1'b1;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      shutdown_o <= 1'b0;
    else if (test_fail || (forbidden && !in_test))
      shutdown_o <= 1'b1;
  end

endmodule : flame_supervision_logic

`default_nettype wire

// >>> verif/flame_sup_checker.sv
// checker: flame combination, config error, self-test and shutdown relations
// assumes binding to flame_supervision_logic on one clock
`timescale 1ns/100ps
`default_nettype none
module flame_sup_checker #(
  parameter int unsigned PHASE_W = 8
) (
  // clock, reset, pins, sequencer
  input wire logic               clk_i, rst_i,
  input wire logic               flame_channel_a_i, flame_channel_b_i,
  input wire logic               a_connected_i, b_connected_i,
  input wire logic [PHASE_W-1:0] phase_i,
  input wire logic               fuel_oil_i,
  input wire logic [2:0]         gas_pilot_select_i, oil_pilot_select_i,
  input wire logic [2:0]         gas_operating_select_i, oil_operating_select_i,
  input wire logic [2:0]         gas_stray_light_select_i, oil_stray_light_select_i,
  // results
  input wire logic               flame_o, config_error_o, test_supply_raise_o,
  input wire logic               self_test_active_o, detector_fault_o, shutdown_o
);
  // ==========
  // history: pins lag three edges, selection one
  wire pil = phase_i >= flame_sup_pkg::PILOT_FIRST && phase_i <= flame_sup_pkg::PILOT_LAST;
  wire opr = phase_i >= flame_sup_pkg::OPER_FIRST && phase_i <= flame_sup_pkg::OPER_LAST;
  wire [2:0] cur = pil ? (fuel_oil_i ? oil_pilot_select_i : gas_pilot_select_i)
    : opr ? (fuel_oil_i ? oil_operating_select_i : gas_operating_select_i)
    : (fuel_oil_i ? oil_stray_light_select_i : gas_stray_light_select_i);
  logic [2:0] ah, bh, cc, up, ep;
  logic [3:0] tq;
  logic       op;
  logic       xf;
  wire ok = up[2] && tq == 4'h0 && !self_test_active_o && !shutdown_o;
  always_ff @(posedge clk_i)
  begin
    ah <= {ah[1:0], flame_channel_a_i};
    bh <= {bh[1:0], flame_channel_b_i};
    cc <= {cc[1:0], a_connected_i & b_connected_i};
    ep <= (!pil && !opr && cur == flame_sup_pkg::SEL_BOTH) ? 3'h7 : cur;
    op <= opr;
    tq <= {tq[2:0], self_test_active_o};
    up <= rst_i ? 3'h0 : up + {2'h0, !up[2]};
  end
  // codes follow the package settings 0..6
  always_comb
  begin
    case (ep)
      3'h0, 3'h1: xf = ah[2] | bh[2];
      3'h2: xf = ah[2] & !bh[2];
      3'h3: xf = ah[2];
      3'h4: xf = bh[2] & !ah[2];
      3'h5: xf = bh[2];
      3'h6: xf = ah[2] & bh[2];
      default: xf = 1'b0;
    endcase
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  comb_result_a:
    assert property (ok |-> flame_o == xf) else $error("combined flame wrong");
  single_err_a:
    assert property (ok |-> config_error_o == (ep == 3'h0 && cc[2])) else $error("config error");
  supply_test_a:
    assert property (test_supply_raise_o == self_test_active_o) else $error("supply raise");
  test_hold_a:
    assert property (self_test_active_o && $past(self_test_active_o) |-> $stable(flame_o))
      else $error("flame changed in test");
  test_len_a:
    assert property ($rose(self_test_active_o) |-> self_test_active_o [*8]) else $error("test short");
  recover_hold_a:
    assert property ($fell(self_test_active_o) |-> $stable(flame_o) [*3])
      else $error("flame dropped after test");
  test_gap_a:
    assert property ($fell(self_test_active_o) |-> !self_test_active_o [*8]) else $error("test gap");
  fault_shut_a:
    assert property ($rose(detector_fault_o) |-> shutdown_o ##1 detector_fault_o)
      else $error("fault without shutdown");
  forbid_shut_a:
    assert property (ok && op && (ep == 3'h2 && bh[2] || ep == 3'h4 && ah[2]) |-> ##[0:2] shutdown_o)
      else $error("forbidden flame kept running");
endmodule : flame_sup_checker
bind flame_supervision_logic flame_sup_checker #(.PHASE_W(PHASE_W)) chk_u (.*);
`default_nettype wire

// >>> verif/flame_detector_model.sv
// partner model: optical detector and ionisation probe pins
// assumes a healthy optical cell drops its signal under raised supply
`timescale 1ns/100ps
`default_nettype none
module flame_detector_model (
  // scene and health
  input  wire logic flame_seen_i,
  input  wire logic ion_seen_i,
  input  wire logic broken_i,
  input  wire logic supply_raise_i,
  // pins
  output logic      flame_channel_a_o,
  output logic      flame_channel_b_o
);
  // ==========
  // a broken cell keeps reporting flame: the case the self-test must catch
  assign flame_channel_a_o = flame_seen_i & (broken_i | !supply_raise_i);
  assign flame_channel_b_o = ion_seen_i;
endmodule : flame_detector_model
`default_nettype wire

// >>> verif/flame_supervision_logic_tb_top.sv
// testbench: combination table, forbidden flame, self-test pass and fault
// assumes short self-test counts handed in by parameter
`timescale 1ns/100ps
`default_nettype none
module flame_supervision_logic_tb_top;
  // ==========
  logic       clk_i = 1'b0, rst_i = 1'b1, sa = 1'b0, sb = 1'b0, brk = 1'b0, ten = 1'b0;
  logic       fuel = 1'b0, ca = 1'b1, cb = 1'b1;
  logic [7:0] ph = 8'h00;
  logic [2:0] sel [6] = '{default: 3'h7};
  wire        a, b, fl, ce, sr, ta, df, sd;
  int         err_count = 0, compares = 0;
  initial forever #4 clk_i = ~clk_i;
  flame_detector_model det_u (.flame_seen_i(sa), .ion_seen_i(sb), .broken_i(brk),
    .supply_raise_i(sr), .flame_channel_a_o(a), .flame_channel_b_o(b));
  flame_supervision_logic #(.TEST_PERIOD(50), .TEST_TIME(10)) dut_u (.clk_i(clk_i),
    .rst_i(rst_i), .flame_channel_a_i(a), .flame_channel_b_i(b), .a_connected_i(ca),
    .b_connected_i(cb), .phase_i(ph), .fuel_oil_i(fuel), .self_test_enable_i(ten),
    .gas_pilot_select_i(sel[0]), .oil_pilot_select_i(sel[1]), .gas_operating_select_i(sel[2]),
    .oil_operating_select_i(sel[3]), .gas_stray_light_select_i(sel[4]),
    .oil_stray_light_select_i(sel[5]), .flame_o(fl), .config_error_o(ce),
    .test_supply_raise_o(sr), .self_test_active_o(ta), .detector_fault_o(df), .shutdown_o(sd));
  task automatic check(input logic seen, input logic want);
    compares++;
    if (seen !== want)
    begin
      err_count++;
      $display("wrong value at %0t: got %b want %b", $time, seen, want);
    end
  endtask : check
  task automatic test_done;
    $display("errors %0d compares %0d", err_count, compares);
    if (err_count == 0 && compares > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : test_done
  task automatic cycles(input int n);
    repeat (n) @(negedge clk_i);
  endtask : cycles
  task automatic wait_test(input logic v);
    for (int i = 0; i < 200 && ta !== v; i++) @(negedge clk_i);
    if (ta !== v)
    begin
      err_count++;
      test_done();
    end
  endtask : wait_test
  task automatic restart;
    rst_i = 1'b1;
    cycles(12);
    rst_i = 1'b0;
  endtask : restart
  // ==========
  // every setting under pilot and operating phases, all but 2 and 4 under stray, both fuels, boundaries
  task automatic combo_table;
    logic [7:0] phs [6] = '{8'h28, 8'h34, 8'h33, 8'h32, 8'h3E, 8'h3F};
    logic x;
    for (int f = 0; f < 2; f++)
      for (int r = 0; r < 3; r++)
        for (int s = 0; s < 7; s++)
          for (int ab = 0; ab < 4; ab++)
          begin
            if (r == 2 && (s == 2 || s == 4)) continue;
            if (r == 1) restart();
            sel = '{default: 3'h7};
            sel[2*r+f] = 3'(s);
            fuel = f[0];
            ph = phs[3*f+r];
            {sa, sb} = 2'(ab);
            cb = ab[0];
            cycles(4);
            case (s)
              0, 1: x = sa | sb;
              2: x = sa & !sb;
              3: x = sa;
              4: x = sb & !sa;
              5: x = sb;
              default: x = (r == 2) ? 1'b0 : sa & sb;
            endcase
            check(fl, x);
            check(ce, s == 0 && ab[0]);
            check(sd, r == 1 && (s == 2 && sb || s == 4 && sa));
          end
  endtask : combo_table
  // ==========
  // healthy test first, then a cell that never drops its signal
  task automatic self_test_run;
    restart();
    sel = '{default: 3'h3};
    ph = 8'h3A;
    sa = 1'b1;
    ten = 1'b1;
    wait_test(1'b1);
    check(sr, 1'b1);
    check(fl, 1'b1);
    wait_test(1'b0);
    check(fl, 1'b1);
    check(df, 1'b0);
    check(sd, 1'b0);
    cycles(4);
    check(fl, 1'b1);
    cycles(20);
    check(ta, 1'b0);
    brk = 1'b1;
    wait_test(1'b1);
    wait_test(1'b0);
    cycles(2);
    check(df, 1'b1);
    check(sd, 1'b1);
  endtask : self_test_run
  initial
  begin
    restart();
    combo_table();
    self_test_run();
    test_done();
  end
endmodule : flame_supervision_logic_tb_top
`default_nettype wire
